// ### slps_regs.svh
`ifndef SLPS_REGS_SVH
`define SLPS_REGS_SVH
// Function
// - Straps set default configuration on every reset
// - Capture strap levels at reset release
// - Serial pins have exactly two modes
// - Pull-ups on data-out and clock select bus slave
// - No pull on both pins selects ROM master
// - Pin functions follow the selected mode
// - Capture on power-on and external reset release
// - Boot goes host-config or one-time-config

// Strap sense codes from the pad resistor detector
`define SLPS_SENSE_NONE 2'h0
`define SLPS_SENSE_PU 2'h1
`define SLPS_SENSE_PD 2'h2
`define SLPS_SENSE_W 2
// Firmware signature address in the ROM
`define SLPS_SIG_ADDR 16'hFFFA
`endif

// ### slps_pkg.sv
package slps_pkg;
  typedef enum logic [0:0] {
    SLPS_MODE_ROM = 1'b0,
    SLPS_MODE_HOST = 1'b1
  } slps_mode_t;
  typedef enum logic [1:0] {
    SLPS_ST_RESET = 2'b00,
    SLPS_ST_LATCH = 2'b01,
    SLPS_ST_HOLD = 2'b10
  } slps_state_t;
endpackage : slps_pkg

// ### slps_strap_latch.sv
`include "slps_regs.svh"

module slps_strap_latch (
  // Clock and reset (power-on reset folded in by the reset tree)
  input wire logic core_clk,
  input wire logic rst_n,
  // Strap sense from pad detectors
  input wire logic [1:0] dataOutSense,
  input wire logic [1:0] clockSense,
  // Pad inputs
  input wire logic romDataInPin,
  input wire logic hostBusDataPinIn,
  input wire logic hostBusClockPinIn,
  input wire logic fixedPortCountStrapIn,
  input wire logic chargingPortsStrapIn,
  // Core side ROM master
  input wire logic romSelect,
  input wire logic romDataOut,
  input wire logic romClock,
  // Core side host bus slave
  input wire logic hostDataDriveLow,
  input wire logic hostClockDriveLow,
  // Pad drives, enables active low
  output logic romChipSelectN,
  output logic romChipSelectOeN,
  output logic dataOutPinOut,
  output logic dataOutPinOeN,
  output logic clockPinOut,
  output logic clockPinOeN,
  // Core side results
  output logic romDataIn,
  output logic hostBusDataIn,
  output logic hostBusClockIn,
  output logic fixedPortCountStrap,
  output logic chargingPortsStrap,
  output logic hostMode,
  output logic strapsValid,
  output logic bootToHostConfig,
  output logic bootToOtpConfig
);

  slps_pkg::slps_state_t state;
  slps_pkg::slps_mode_t mode;
  logic sampledHost;

  function automatic logic pullUpSeen(input logic [`SLPS_SENSE_W-1:0] s);
    pullUpSeen = (s == `SLPS_SENSE_PU);
  endfunction : pullUpSeen

  // ---------------------------------------------
  // Latch sequencing
  // ---------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= slps_pkg::SLPS_ST_RESET;
    end else begin
      case (state)
        slps_pkg::SLPS_ST_RESET: state <= slps_pkg::SLPS_ST_LATCH;
        slps_pkg::SLPS_ST_LATCH: state <= slps_pkg::SLPS_ST_HOLD;
        default: state <= slps_pkg::SLPS_ST_HOLD;
      endcase
    end
  end

  // Mode decision from the sensed straps
  always_comb begin
    sampledHost = pullUpSeen(dataOutSense) && pullUpSeen(clockSense);
  end

  // First clock after release captures, then hold
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode <= slps_pkg::SLPS_MODE_ROM;
      hostMode <= 1'b0;
      strapsValid <= 1'b0;
      bootToHostConfig <= 1'b0;
      bootToOtpConfig <= 1'b0;
    end else if (state == slps_pkg::SLPS_ST_RESET) begin
      // Anything else than both pull-ups means ROM master
      mode <= sampledHost ? slps_pkg::SLPS_MODE_HOST : slps_pkg::SLPS_MODE_ROM;
      hostMode <= sampledHost;
      strapsValid <= 1'b1;
      bootToHostConfig <= sampledHost;
      bootToOtpConfig <= !sampledHost;
    end // Held until next reset
  end

  // Extra straps only meaningful in host bus mode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fixedPortCountStrap <= 1'b0;
      chargingPortsStrap <= 1'b0;
    end else if (state == slps_pkg::SLPS_ST_RESET && sampledHost) begin
      fixedPortCountStrap <= fixedPortCountStrapIn;
      chargingPortsStrap <= chargingPortsStrapIn;
    end
  end

  // ---------------------------------------------
  // Pin function routing
  // ---------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      romChipSelectN <= 1'b1;
      romChipSelectOeN <= 1'b1;
      dataOutPinOut <= 1'b0;
      dataOutPinOeN <= 1'b1;
      clockPinOut <= 1'b0;
      clockPinOeN <= 1'b1;
      romDataIn <= 1'b0;
      hostBusDataIn <= 1'b1;
      hostBusClockIn <= 1'b1;
    end else if (state != slps_pkg::SLPS_ST_HOLD) begin
      romChipSelectOeN <= 1'b1;
      dataOutPinOeN <= 1'b1;
      clockPinOeN <= 1'b1;
    end else if (mode == slps_pkg::SLPS_MODE_ROM) begin
      romChipSelectN <= !romSelect;
      romChipSelectOeN <= 1'b0;
      dataOutPinOut <= romDataOut;
      dataOutPinOeN <= 1'b0;
      clockPinOut <= romClock;
      clockPinOeN <= 1'b0;
      romDataIn <= romDataInPin;
      hostBusDataIn <= 1'b1;
      hostBusClockIn <= 1'b1;
    end else begin
      romChipSelectN <= 1'b1;
      romChipSelectOeN <= 1'b1;
      dataOutPinOut <= 1'b0;
      dataOutPinOeN <= !hostDataDriveLow;
      clockPinOut <= 1'b0;
      clockPinOeN <= !hostClockDriveLow;
      romDataIn <= 1'b0;
      hostBusDataIn <= hostBusDataPinIn;
      hostBusClockIn <= hostBusClockPinIn;
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  a_host_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == slps_pkg::SLPS_ST_RESET |=> hostMode == $past(sampledHost))
    else $error("mode not taken from straps");
  a_rom_default: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == slps_pkg::SLPS_ST_RESET && !sampledHost |=> !hostMode)
    else $error("rom mode not selected");
  a_capture_release: assert property (@(posedge core_clk)
    !rst_n |=> !strapsValid)
    else $error("valid during reset");
  a_capture_once: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |=> strapsValid)
    else $error("no capture after release");
  a_mode_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    strapsValid |=> $stable(hostMode) && $stable(fixedPortCountStrap))
    else $error("latched value changed");
  a_boot_path: assert property (@(posedge core_clk) disable iff (!rst_n)
    strapsValid |-> bootToHostConfig == hostMode
      && bootToOtpConfig == !hostMode)
    else $error("wrong boot path");
  a_two_modes: assert property (@(posedge core_clk) disable iff (!rst_n)
    strapsValid |-> hostMode == (mode == slps_pkg::SLPS_MODE_HOST))
    else $error("mode flags disagree");
  a_rom_pins: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == slps_pkg::SLPS_ST_HOLD && !hostMode
      |=> !clockPinOeN && !romChipSelectOeN)
    else $error("rom pins not driven");
  a_host_pins: assert property (@(posedge core_clk) disable iff (!rst_n)
    strapsValid && hostMode |-> romChipSelectOeN && romChipSelectN)
    else $error("chip select driven in host mode");
  a_reset_state: assert property (@(posedge core_clk)
    !rst_n |=> state == slps_pkg::SLPS_ST_RESET)
    else $error("reset state not entered");
  a_host_drain: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == slps_pkg::SLPS_ST_HOLD && hostMode |=> !dataOutPinOut && !clockPinOut)
    else $error("host pins not open drain");
  a_pull_down_rom: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == slps_pkg::SLPS_ST_RESET && (dataOutSense == `SLPS_SENSE_PD
      || clockSense == `SLPS_SENSE_PD) |=> !hostMode)
    else $error("pull-down gave host mode");
  a_no_pull_rom: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == slps_pkg::SLPS_ST_RESET && dataOutSense == `SLPS_SENSE_NONE
      && clockSense == `SLPS_SENSE_NONE |=> !hostMode)
    else $error("no pull gave host mode");
  a_strap_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    strapsValid && !hostMode |-> !fixedPortCountStrap && !chargingPortsStrap)
    else $error("straps taken in rom mode");
  a_rom_in_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    strapsValid && hostMode |-> !romDataIn)
    else $error("rom input active in host mode");
  a_host_in_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    strapsValid && !hostMode |-> hostBusDataIn && hostBusClockIn)
    else $error("bus inputs active in rom mode");
  a_pads_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    state != slps_pkg::SLPS_ST_HOLD
      |=> dataOutPinOeN && clockPinOeN && romChipSelectOeN)
    else $error("pads driven before capture");
  a_boot_one_hot: assert property (@(posedge core_clk) disable iff (!rst_n)
    strapsValid |-> bootToHostConfig != bootToOtpConfig)
    else $error("boot path not one hot");
  a_strap_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == slps_pkg::SLPS_ST_RESET && sampledHost
      |=> fixedPortCountStrap == $past(fixedPortCountStrapIn))
    else $error("strap not captured");

  // ---------------------------------------------
  // Cover points
  // ---------------------------------------------

  c_host_mode: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(strapsValid) && hostMode);
  c_rom_mode: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(strapsValid) && !hostMode);
  c_pin_change_held: cover property (@(posedge core_clk) disable iff (!rst_n)
    strapsValid && $changed(dataOutSense));
  c_pull_down: cover property (@(posedge core_clk) disable iff (!rst_n)
    state == slps_pkg::SLPS_ST_RESET && dataOutSense == `SLPS_SENSE_PD);
  c_midrun_reset: cover property (@(posedge core_clk)
    strapsValid ##1 !rst_n);

endmodule : slps_strap_latch

// ### slps_rom_model.sv
module slps_rom_model (
  // Clock
  input wire logic core_clk,
  // Pads from the hub
  input wire logic csN,
  input wire logic sclk,
  // Pad to the hub
  output logic dataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Signature text stored by the ROM
  localparam logic [31:0] SIG = 32'h32444655;
  logic [4:0] bitIdx = 5'h00;
  logic lastBit = 1'b0;
  logic lastClk = 1'b0;
  always @(posedge core_clk) begin
    lastClk <= sclk;
    if (csN) begin
      bitIdx <= 5'h00;
      lastBit <= ~lastBit;
    end else if (sclk && !lastClk) begin
      bitIdx <= bitIdx + 5'h01;
      lastBit <= SIG[5'h1F - bitIdx];
    end
  end
  assign dataIn = lastBit;
endmodule : slps_rom_model

// ### test_strap_latch_serial_port_select.sv
module test_strap_latch_serial_port_select;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic [1:0] doS = 2'h0, ckS = 2'h0;
  logic fp = 1'b0, cp = 1'b0, rs = 1'b0, rdo = 1'b0, rck = 1'b0;
  logic hdl = 1'b0, hcl = 1'b0, busD = 1'b1, busC = 1'b1;
  logic csN, csOeN, dOut, dOeN, cOut, cOeN, romIn, hD, hC, romPin;
  logic fpS, cpS, hostMode, valid, bootH, bootO;
  int seed = 32'hfd2e;
  int errors = 0, samples_checked = 0;
  always #50 core_clk = ~core_clk;
  slps_strap_latch dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .dataOutSense(doS), .clockSense(ckS), .romDataInPin(romPin),
    .hostBusDataPinIn(dOeN ? busD : dOut),
    .hostBusClockPinIn(cOeN ? busC : cOut),
    .fixedPortCountStrapIn(fp), .chargingPortsStrapIn(cp),
    .romSelect(rs), .romDataOut(rdo), .romClock(rck),
    .hostDataDriveLow(hdl), .hostClockDriveLow(hcl),
    .romChipSelectN(csN), .romChipSelectOeN(csOeN),
    .dataOutPinOut(dOut), .dataOutPinOeN(dOeN), .clockPinOut(cOut),
    .clockPinOeN(cOeN), .romDataIn(romIn), .hostBusDataIn(hD),
    .hostBusClockIn(hC), .fixedPortCountStrap(fpS),
    .chargingPortsStrap(cpS), .hostMode(hostMode), .strapsValid(valid),
    .bootToHostConfig(bootH), .bootToOtpConfig(bootO));
  slps_rom_model rom_u (.core_clk(core_clk), .csN(csN | csOeN),
    .sclk(cOut), .dataIn(romPin));
  task automatic chk(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  function automatic logic expHost(input logic [1:0] a, input logic [1:0] b);
    return a == 2'h1 && b == 2'h1;
  endfunction : expHost
  initial begin
    logic hm, ef, ec, pr;
    for (int i = 0; i < 24; i++) begin
      @(negedge core_clk);
      rst_n = 1'b0;
      {doS, ckS, fp, cp} = 6'($random(seed));
      // All nine pairs of the three sense codes first, then random ones
      if (i < 9) {doS, ckS} = {2'(i % 3), 2'(i / 3)};
      repeat (5) @(negedge core_clk);
      chk(valid, 1'b0, "valid in reset");
      chk(dOeN & cOeN & csOeN, 1'b1, "pads idle in reset");
      rst_n = 1'b1;
      hm = expHost(doS, ckS);
      ef = hm & fp;
      ec = hm & cp;
      @(negedge core_clk);
      chk(valid, 1'b1, "valid");
      chk(hostMode, hm, "mode");
      chk(bootH, hm, "boot host");
      chk(bootO, !hm, "boot otp");
      {doS, ckS, fp, cp} = 6'($random(seed));
      {rs, rdo, rck, hdl, hcl, busD, busC} = 7'($random(seed));
      repeat (2) @(negedge core_clk);
      pr = romPin;
      @(negedge core_clk);
      chk(hostMode, hm, "mode held");
      chk(fpS, ef, "strap a");
      chk(cpS, ec, "strap b");
      if (hm) begin
        chk(dOeN, !hdl, "data drive");
        chk(cOeN, !hcl, "clock drive");
        chk(hD, busD & !hdl, "data in");
        chk(hC, busC & !hcl, "clock in");
        chk(dOut | cOut, 1'b0, "drive levels low");
        chk(romIn, 1'b0, "rom data idle");
        chk(csN & csOeN, 1'b1, "select released");
      end else begin
        chk(csN, !rs, "select");
        chk(dOut, rdo, "data out");
        chk(cOut | cOeN, rck, "clock out");
        chk(romIn, pr, "rom data");
        chk(dOeN | csOeN, 1'b0, "rom pads driven");
        chk(hD & hC, 1'b1, "bus inputs idle");
      end
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule : test_strap_latch_serial_port_select
